// *** hw/nvm_seq_pkg.sv ***
// constants shared by the flash erase/write sequencer
// assumes a 40 MHz core clock and a classic wishbone register bus
package nvm_seq_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_READY_FLAG       = 12'h0400;
    localparam logic [11:0] OFF_WRITE_ERASE_CFG  = 12'h0504;
    localparam logic [11:0] OFF_PAGE_ERASE       = 12'h0508;
    localparam logic [11:0] OFF_WHOLE_ERASE      = 12'h050C;
    localparam logic [11:0] OFF_LEGACY_ERASE_B   = 12'h0510;
    localparam logic [11:0] OFF_USER_ERASE       = 12'h0514;
    localparam logic [11:0] OFF_PARTIAL_ERASE    = 12'h0518;
    localparam logic [11:0] OFF_PARTIAL_DURATION = 12'h051C;
    localparam logic [11:0] OFF_PARTIAL_STATUS   = 12'h0520;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int          WEN_LSB             = 0;
    localparam int          WEN_WIDTH           = 2;
    localparam logic [1:0]  WEN_READ_ONLY       = 2'h0;
    localparam logic [1:0]  WEN_WRITE           = 2'h1;
    localparam logic [1:0]  WEN_ERASE           = 2'h2;
    localparam logic [1:0]  WEN_RESET           = 2'h0;
    localparam int          PART_DUR_WIDTH      = 7;
    localparam logic [6:0]  PART_DUR_RESET      = 7'h0A;
    localparam int          STAT_ACC_LSB        = 0;
    localparam int          STAT_CYCLES_LSB     = 16;
    localparam logic [31:0] TRIGGER_START       = 32'h0000_0001;
    localparam logic [31:0] NO_ACTION_VALUE     = 32'h0000_0000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ             = 40;
    localparam int T_WRITE_US          = 41;
    localparam int T_ERASE_PAGE_MS     = 85;
    localparam int T_ERASE_ALL_MS      = 169;
    localparam int WRITE_CYCLES        = T_WRITE_US * CLK_MHZ;
    localparam int MS_CYCLES           = CLK_MHZ * 1000;
    localparam int ERASE_PAGE_CYCLES   = T_ERASE_PAGE_MS * MS_CYCLES;
    localparam int ERASE_ALL_CYCLES    = T_ERASE_ALL_MS * MS_CYCLES;
    localparam int TIMER_WIDTH         = 24;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PROGRAM,
        ST_ERASE_PAGE,
        ST_ERASE_PARTIAL,
        ST_ERASE_USER,
        ST_ERASE_ALL
    } seq_state_e;

endpackage : nvm_seq_pkg

// *** hw/op_timer.sv ***
// one-shot cycle timer for the sequencer's operation lengths
// assumes load is a one-cycle pulse and value is at least one
`timescale 1ns/1ps
module op_timer #(
    parameter int WIDTH = 24
) (
    input  wire logic             core_clk,
    input  wire logic             nrst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] value,
    output logic                  expired
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } timer_s;

    timer_s s;
    timer_s next_s;

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        if (load) begin
            next_s.count = value;
        end else if (s.count != '0) begin
            next_s.count = s.count - WIDTH'(1);
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // pulse in the last counted cycle, so an op lasts exactly value cycles
    assign expired = (s.count == WIDTH'(1));

endmodule : op_timer

// *** hw/flash_erase_write_sequencer.sv ***
// flash erase/write sequencer: wishbone registers, word program, erases
// assumes a flash macro that holds erase/program while its level is high
// and presents the addressed word on flashRdData in the same cycle
`timescale 1ns/1ps
module flash_erase_write_sequencer
    import nvm_seq_pkg::*;
#(
    parameter int MS_CYCLE_COUNT    = nvm_seq_pkg::MS_CYCLES,
    parameter int ERASE_PAGE_COUNT  = nvm_seq_pkg::ERASE_PAGE_CYCLES,
    parameter int ERASE_ALL_COUNT   = nvm_seq_pkg::ERASE_ALL_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // wishbone slave
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [11:0] wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatW,
    output logic      [31:0] wbDatR,
    output logic             wbAck,
    // processor word write into flash or user area
    input  wire logic        cpuWrReq,
    input  wire logic        cpuWrUser,
    input  wire logic [31:0] cpuWrAddr,
    input  wire logic [31:0] cpuWrData,
    output logic             cpuWrStall,
    output logic             cpuWrDone,
    // flash macro
    input  wire logic [31:0] flashRdData,
    output logic      [31:0] flashAddr,
    output logic      [31:0] flashWrData,
    output logic             flashUserArea,
    output logic             flashProgram,
    output logic             flashErasePage,
    output logic             flashEraseUser,
    output logic             flashEraseAll,
    output logic             pageEraseCycle
);

    import nvm_seq_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        seq_state_e                 state;
        logic                       ack;
        logic [31:0]                rdData;
        logic [1:0]                 wen;
        logic [PART_DUR_WIDTH-1:0]  partDur;
        logic [31:0]                fAddr;
        logic [31:0]                fData;
        logic                       userArea;
        logic                       prog;
        logic                       erPage;
        logic                       erUser;
        logic                       erAll;
        logic                       wrDone;
        logic [31:0]                partPage;
        logic [7:0]                 partAcc;
        logic [15:0]                eraseCycles;
        logic                       cycPulse;
    } seq_s;

    seq_s                   s;
    seq_s                   next_s;
    logic                   timerLoad;
    logic [TIMER_WIDTH-1:0] timerValue;
    logic                   timerExpired;
    logic                   busWrite;
    logic                   busRead;
    logic [31:0]            busData;
    logic                   eraseOk;
    logic [8:0]             accSum;
    logic                   cfgWrite;
    logic                   durWrite;
    logic                   cpuTake;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // byte lanes not selected contribute zero
    function automatic logic [31:0] laneMask(input logic [31:0] d, input logic [3:0] sel);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : laneMask

    function automatic logic [TIMER_WIDTH-1:0] toCycles(input int n);
        return TIMER_WIDTH'(n);
    endfunction : toCycles

    // only the value one starts a whole or user erase; zero and all others are no action
    function automatic logic isStart(input logic [31:0] d);
        return d == TRIGGER_START;
    endfunction : isStart

    op_timer #(
        .WIDTH   (TIMER_WIDTH)
    ) u_timer (
        .core_clk (core_clk),
        .nrst     (nrst),
        .load     (timerLoad),
        .value    (timerValue),
        .expired  (timerExpired)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // one wait state: ack one cycle after the request, dropped after
    assign busWrite = wbCyc && wbStb && !s.ack && wbWe;
    assign busRead  = wbCyc && wbStb && !s.ack && !wbWe;
    assign busData  = laneMask(wbDatW, wbSel);
    assign eraseOk  = (s.wen == WEN_ERASE);
    assign accSum   = 9'(s.partAcc) + 9'(s.partDur);

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    assign cfgWrite = busWrite && (wbAdr == OFF_WRITE_ERASE_CFG);
    assign durWrite = busWrite && (wbAdr == OFF_PARTIAL_DURATION);
    // the request still stands in its done cycle; it must not be taken twice
    assign cpuTake  = cpuWrReq && !s.wrDone;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s          = s;
        timerLoad       = 1'b0;
        timerValue      = '0;
        next_s.ack      = wbCyc && wbStb && !s.ack;
        next_s.wrDone   = 1'b0;
        next_s.cycPulse = 1'b0;

        if (busRead) begin
            case (wbAdr)
                OFF_READY_FLAG: begin
                    next_s.rdData = {31'h0000_0000, s.state == ST_IDLE};
                end
                OFF_WRITE_ERASE_CFG: begin
                    next_s.rdData = 32'(s.wen) << WEN_LSB;
                end
                OFF_PARTIAL_DURATION: begin
                    next_s.rdData = 32'(s.partDur);
                end
                OFF_PARTIAL_STATUS: begin
                    next_s.rdData = (32'(s.eraseCycles) << STAT_CYCLES_LSB)
                                  | (32'(s.partAcc) << STAT_ACC_LSB);
                end
                default: begin
                    // write-only and unmapped offsets read as zero
                    next_s.rdData = '0;
                end
            endcase
        end

        // configuration writes land at any time
        if (cfgWrite) begin
            next_s.wen = busData[WEN_LSB +: WEN_WIDTH];
        end
        if (durWrite) begin
            next_s.partDur = busData[PART_DUR_WIDTH-1:0];
        end

        case (s.state)
            ST_IDLE: begin
                if (cpuTake && s.wen == WEN_WRITE) begin
                    // old & new: bits can only fall to zero
                    next_s.fAddr    = cpuWrAddr;
                    next_s.fData    = flashRdData & cpuWrData;
                    next_s.userArea = cpuWrUser;
                    next_s.prog     = 1'b1;
                    next_s.state    = ST_PROGRAM;
                    timerLoad       = 1'b1;
                    timerValue      = toCycles(WRITE_CYCLES);
                end else if (cpuTake) begin
                    // not enabled: the write is dropped, the stall released
                    next_s.wrDone = 1'b1;
                end else if (busWrite && eraseOk) begin
                    case (wbAdr)
                        OFF_PAGE_ERASE, OFF_LEGACY_ERASE_B: begin
                            next_s.fAddr    = busData;
                            next_s.userArea = 1'b0;
                            next_s.erPage   = 1'b1;
                            next_s.state    = ST_ERASE_PAGE;
                            timerLoad       = 1'b1;
                            timerValue      = toCycles(ERASE_PAGE_COUNT);
                        end
                        OFF_WHOLE_ERASE: begin
                            if (isStart(busData)) begin
                                next_s.erAll = 1'b1;
                                next_s.state = ST_ERASE_ALL;
                                timerLoad    = 1'b1;
                                timerValue   = toCycles(ERASE_ALL_COUNT);
                            end
                        end
                        OFF_USER_ERASE: begin
                            if (isStart(busData)) begin
                                next_s.userArea = 1'b1;
                                next_s.erUser   = 1'b1;
                                next_s.state    = ST_ERASE_USER;
                                timerLoad       = 1'b1;
                                timerValue      = toCycles(ERASE_PAGE_COUNT);
                            end
                        end
                        OFF_PARTIAL_ERASE: begin
                            // a zero duration would never end, so it is ignored
                            if (s.partDur != '0) begin
                                next_s.fAddr    = busData;
                                next_s.userArea = 1'b0;
                                next_s.erPage   = 1'b1;
                                next_s.state    = ST_ERASE_PARTIAL;
                                timerLoad       = 1'b1;
                                // factor 1.0, inside the 1.05 bound
                                timerValue      = TIMER_WIDTH'(32'(s.partDur)
                                                  * 32'(MS_CYCLE_COUNT));
                                if (busData != s.partPage) begin
                                    // new page: accumulation restarts
                                    next_s.partPage = busData;
                                    next_s.partAcc  = '0;
                                end
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end

            ST_PROGRAM: begin
                if (timerExpired) begin
                    next_s.prog   = 1'b0;
                    next_s.wrDone = 1'b1;
                    next_s.state  = ST_IDLE;
                end
            end

            ST_ERASE_PAGE: begin
                if (timerExpired) begin
                    // flash macro leaves the page all ones
                    next_s.erPage = 1'b0;
                    if (s.fAddr == s.partPage) begin
                        next_s.partAcc = '0;
                    end
                    next_s.state = ST_IDLE;
                end
            end

            // a remainder past a full page time is dropped, not carried
            ST_ERASE_PARTIAL: begin
                if (timerExpired) begin
                    next_s.erPage = 1'b0;
                    if (accSum >= 9'(T_ERASE_PAGE_MS)) begin
                        next_s.partAcc     = '0;
                        // wraps after 16 bits; software reads differences
                        next_s.eraseCycles = s.eraseCycles + 16'h0001;
                        next_s.cycPulse    = 1'b1;
                    end else begin
                        next_s.partAcc = accSum[7:0];
                    end
                    next_s.state = ST_IDLE;
                end
            end

            ST_ERASE_USER: begin
                if (timerExpired) begin
                    next_s.erUser = 1'b0;
                    next_s.state  = ST_IDLE;
                end
            end

            ST_ERASE_ALL: begin
                if (timerExpired) begin
                    // tracked partial page is erased too
                    next_s.erAll   = 1'b0;
                    next_s.partAcc = '0;
                    next_s.state   = ST_IDLE;
                end
            end

            default: begin
                next_s.state = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s         <= '0;
            s.state   <= ST_IDLE;
            s.wen     <= WEN_RESET;
            s.partDur <= PART_DUR_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wbDatR         = s.rdData;
    assign wbAck          = s.ack;
    // stall holds until the done pulse; request must stay up meanwhile
    assign cpuWrStall     = cpuWrReq && !s.wrDone;
    assign cpuWrDone      = s.wrDone;
    assign flashAddr      = s.fAddr;
    assign flashWrData    = s.fData;
    assign flashUserArea  = s.userArea;
    assign flashProgram   = s.prog;
    assign flashErasePage = s.erPage;
    assign flashEraseUser = s.erUser;
    assign flashEraseAll  = s.erAll;
    assign pageEraseCycle = s.cycPulse;

endmodule : flash_erase_write_sequencer

// *** testbench/flash_seq_sva.sv ***
// checker for the flash sequencer: program and erase lengths, pulses
// bound to the top module; sees only its ports, one clock domain
`timescale 1ns/1ps
module flash_seq_sva
    import nvm_seq_pkg::*;
#(
    parameter int MS_CYCLE_COUNT   = 4,
    parameter int ERASE_PAGE_COUNT = 340,
    parameter int ERASE_ALL_COUNT  = 676
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cpuWrReq,
    input wire logic cpuWrStall,
    input wire logic cpuWrDone,
    input wire logic flashProgram,
    input wire logic flashErasePage,
    input wire logic flashEraseUser,
    input wire logic flashEraseAll,
    input wire logic pageEraseCycle
);
    logic [23:0] progRun;
    logic [23:0] eraseRun;
    // ----------------------------------------
    // run counters, cleared once the level drops
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            progRun  <= '0;
            eraseRun <= '0;
        end else begin
            progRun  <= flashProgram ? progRun + 24'h00_0001 : '0;
            eraseRun <= (flashErasePage | flashEraseUser | flashEraseAll) ?
                        eraseRun + 24'h00_0001 : '0;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    prog_length_a: assert property ($fell(flashProgram) |-> progRun == WRITE_CYCLES)
        else $error("program level length wrong");
    prog_done_a: assert property ($fell(flashProgram) |-> cpuWrDone)
        else $error("program end without done");
    stall_hold_a: assert property (flashProgram |-> cpuWrStall)
        else $error("write not stalled");
    done_pulse_a: assert property (cpuWrDone |=> !cpuWrDone && !flashProgram)
        else $error("done too long or write taken twice");
    page_length_a: assert property ($fell(flashErasePage) |->
        eraseRun <= ERASE_PAGE_COUNT && eraseRun % MS_CYCLE_COUNT == 0)
        else $error("page erase length wrong");
    user_length_a: assert property ($fell(flashEraseUser) |-> eraseRun == ERASE_PAGE_COUNT)
        else $error("user erase length wrong");
    all_length_a: assert property ($fell(flashEraseAll) |-> eraseRun == ERASE_ALL_COUNT)
        else $error("whole erase length wrong");
    ops_exclusive_a: assert property ($onehot0({flashProgram, flashErasePage,
        flashEraseUser, flashEraseAll}))
        else $error("two operations at once");
    cycle_pulse_a: assert property (pageEraseCycle |=> !pageEraseCycle)
        else $error("erase cycle pulse too long");
    cover property ($fell(flashProgram));
    cover property ($fell(flashEraseAll));
    cover property ($fell(flashEraseUser));
    cover property (pageEraseCycle);
endmodule : flash_seq_sva

bind flash_erase_write_sequencer flash_seq_sva #(
    .MS_CYCLE_COUNT(MS_CYCLE_COUNT), .ERASE_PAGE_COUNT(ERASE_PAGE_COUNT),
    .ERASE_ALL_COUNT(ERASE_ALL_COUNT)
) u_flash_seq_sva (
    .core_clk(core_clk), .nrst(nrst), .cpuWrReq(cpuWrReq), .cpuWrStall(cpuWrStall),
    .cpuWrDone(cpuWrDone), .flashProgram(flashProgram), .flashErasePage(flashErasePage),
    .flashEraseUser(flashEraseUser), .flashEraseAll(flashEraseAll),
    .pageEraseCycle(pageEraseCycle)
);

// *** testbench/flash_erase_write_sequencer_tb.sv ***
// self-checking bench for the flash sequencer through its wishbone registers and its cpu write port
// assumes shortened erase counts; inputs change by nba on the rising edge
`timescale 1ns/1ps
module flash_erase_write_sequencer_tb;
    import nvm_seq_pkg::*;
    localparam int MSC = 4;
    localparam int EPC = 85 * MSC;
    localparam int EAC = 169 * MSC;
    logic        core_clk, nrst, wbCyc, wbStb, wbWe, wbAck;
    logic        cpuWrReq, cpuWrUser, cpuWrStall, cpuWrDone, flashUserArea;
    logic        flashProgram, flashErasePage, flashEraseUser, flashEraseAll, pageEraseCycle;
    logic [11:0] wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDatW, wbDatR, cpuWrAddr, cpuWrData, flashRdData, flashAddr, flashWrData, rd;
    logic [2:0]  opSeen;
    int          err_total, checks, opCnt, progCnt, cycCnt;

    flash_erase_write_sequencer #(
        .MS_CYCLE_COUNT(MSC), .ERASE_PAGE_COUNT(EPC), .ERASE_ALL_COUNT(EAC)
    ) u_flash_erase_write_sequencer (
        .core_clk(core_clk), .nrst(nrst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
        .cpuWrReq(cpuWrReq), .cpuWrUser(cpuWrUser), .cpuWrAddr(cpuWrAddr),
        .cpuWrData(cpuWrData), .cpuWrStall(cpuWrStall), .cpuWrDone(cpuWrDone),
        .flashRdData(flashRdData), .flashAddr(flashAddr), .flashWrData(flashWrData),
        .flashUserArea(flashUserArea), .flashProgram(flashProgram),
        .flashErasePage(flashErasePage), .flashEraseUser(flashEraseUser),
        .flashEraseAll(flashEraseAll), .pageEraseCycle(pageEraseCycle)
    );

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // level monitors, sampled at the edge
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (flashProgram === 1'b1) progCnt++;
        if ((flashErasePage | flashEraseUser | flashEraseAll) === 1'b1) opCnt++;
        if (pageEraseCycle === 1'b1) cycCnt++;
        opSeen = opSeen | {flashEraseAll, flashEraseUser, flashErasePage};
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wbXfer(input logic we, input logic [11:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= adr;
        wbDatW <= dat;
        @(posedge core_clk);
        while (wbAck !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        err_total += (n >= 50);
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge core_clk);
    endtask : wbXfer

    // polls ready; bounded so a stuck flag ends in a failed ready check
    task automatic waitIdle();
        int n;
        n = 0;
        do begin
            wbXfer(1'b0, OFF_READY_FLAG, 32'h0000_0000);
            n++;
        end while (rd[0] !== 1'b1 && n < 1000);
        check(rd[0], 1'b1);
    endtask : waitIdle

    task automatic eraseOp(input logic [11:0] adr, input logic [31:0] dat,
                           input int expCnt, input logic [2:0] expSeen);
        opCnt  = 0;
        opSeen = '0;
        wbXfer(1'b1, adr, dat);
        wbXfer(1'b0, OFF_READY_FLAG, 32'h0000_0000);
        check(rd[0], expCnt == 0);
        waitIdle();
        check(opCnt, expCnt);
        check(opSeen, expSeen);
    endtask : eraseOp

    task automatic cpuWrite(input logic user, input logic [31:0] addr, dat, old,
                            input int expProg);
        int n;
        n = 0;
        progCnt = 0;
        cpuWrReq    <= 1'b1;
        cpuWrUser   <= user;
        cpuWrAddr   <= addr;
        cpuWrData   <= dat;
        flashRdData <= old;
        @(posedge core_clk);
        check(cpuWrStall, 1'b1);
        while (cpuWrDone !== 1'b1 && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        check(cpuWrDone, 1'b1);
        cpuWrReq <= 1'b0;
        check(progCnt, expProg);
        if (expProg > 0) begin
            check(flashWrData, old & dat);
            check(flashAddr, addr);
            check(flashUserArea, user);
        end
        @(posedge core_clk);
        check(cpuWrStall, 1'b0);
    endtask : cpuWrite

    task automatic conclude();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        {nrst, wbCyc, wbStb, wbWe, cpuWrReq, cpuWrUser} = '0;
        {wbAdr, wbDatW, cpuWrAddr, cpuWrData, flashRdData} = '0;
        wbSel = 4'hF;
        {err_total, checks, opCnt, progCnt, cycCnt} = '0;
        opSeen = '0;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        wbXfer(1'b0, OFF_READY_FLAG, 32'h0000_0000);
        check(rd[0], 1'b1);
        wbXfer(1'b0, OFF_WRITE_ERASE_CFG, 32'h0000_0000);
        check(rd, {30'h0, WEN_RESET});
        wbXfer(1'b0, OFF_PARTIAL_DURATION, 32'h0000_0000);
        check(rd, {25'h0, PART_DUR_RESET});
        wbXfer(1'b0, 12'h7FC, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        // read-only: neither erase nor program may act
        eraseOp(OFF_WHOLE_ERASE, TRIGGER_START, 0, 3'b000);
        cpuWrite(1'b0, 32'h0000_0100, 32'h1234_FFFF, 32'hFFFF_0F0F, 0);
        wbXfer(1'b1, OFF_WRITE_ERASE_CFG, {30'h0, WEN_WRITE});
        cpuWrite(1'b0, 32'h0000_0100, 32'h1234_FFFF, 32'hFFFF_0F0F, WRITE_CYCLES);
        cpuWrite(1'b0, 32'h0000_0100, 32'hFFFF_00FF, 32'h1234_0F0F, WRITE_CYCLES);
        cpuWrite(1'b1, 32'h0000_0010, 32'h0000_FFFF, 32'hFFFF_FFFF, WRITE_CYCLES);
        eraseOp(OFF_USER_ERASE, TRIGGER_START, 0, 3'b000);
        wbXfer(1'b1, OFF_WRITE_ERASE_CFG, 32'h0000_0003);
        eraseOp(OFF_PAGE_ERASE, 32'h0000_1000, 0, 3'b000);
        wbXfer(1'b1, OFF_WRITE_ERASE_CFG, {30'h0, WEN_ERASE});
        cpuWrite(1'b0, 32'h0000_0200, 32'h0000_0000, 32'hFFFF_FFFF, 0);
        eraseOp(OFF_PAGE_ERASE, 32'h0000_1000, EPC, 3'b001);
        check(flashAddr, 32'h0000_1000);
        eraseOp(OFF_LEGACY_ERASE_B, 32'h0000_2000, EPC, 3'b001);
        check(flashAddr, 32'h0000_2000);
        eraseOp(OFF_USER_ERASE, NO_ACTION_VALUE, 0, 3'b000);
        eraseOp(OFF_USER_ERASE, TRIGGER_START, EPC, 3'b010);
        eraseOp(OFF_WHOLE_ERASE, NO_ACTION_VALUE, 0, 3'b000);
        eraseOp(OFF_WHOLE_ERASE, TRIGGER_START, EAC, 3'b100);
        wbXfer(1'b1, OFF_PARTIAL_DURATION, 32'h0000_0000);
        eraseOp(OFF_PARTIAL_ERASE, 32'h0000_3000, 0, 3'b000);
        // five chunks of 17 ms add up to exactly one page erase time
        wbXfer(1'b1, OFF_PARTIAL_DURATION, 32'h0000_0011);
        wbXfer(1'b0, OFF_PARTIAL_DURATION, 32'h0000_0000);
        check(rd, 32'h0000_0011);
        cycCnt = 0;
        for (int i = 0; i < 5; i++) begin
            check(cycCnt, 0);
            eraseOp(OFF_PARTIAL_ERASE, 32'h0000_3000, 17 * MSC, 3'b001);
        end
        check(cycCnt, 1);
        wbXfer(1'b0, OFF_PARTIAL_STATUS, 32'h0000_0000);
        check(rd[31:16], 16'h0001);
        conclude();
    end

    initial begin
        repeat (30000) @(posedge core_clk);
        err_total++;
        conclude();
    end
endmodule : flash_erase_write_sequencer_tb
